/* hw/iic_interrupt_and_idle.v */
// Design decisions made here: the APB register port and the address map.
`include "iic_map.vh"
module iic_interrupt_and_idle (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [13:0] src_event,
  input wire instr_done,
  input wire instr_single_cycle,
  input wire return_from_isr_instr,
  input wire supervisory_timer_reset,
  input wire supervisory_timer_lock,
  output reg long_call_instr,
  output reg [15:0] call_vector,
  output reg [3:0] call_source,
  output wire cpu_halt,
  output reg restart_req,
  output wire int_osc_enable,
  output wire timers_enable,
  output wire [1:0] active_level,
  output wire irq
);
  reg [13:0] pend_reg;
  reg [13:0] irq_enable_reg;
  reg [13:0] prio_reg;
  reg [13:0] autoclr_reg;
  reg [7:0] power_control_reg;
  reg global_irq_enable;
  reg global_prev_reg;
  reg idle_reg;
  reg stop_reg;
  reg lost_wake_reg;
  reg in_hi_reg;
  reg in_lo_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  wire wr;
  wire rd;
  wire found;
  wire found_hi;
  wire [3:0] index;
  wire [13:0] req;
  wire [13:0] req_hi;
  wire [13:0] req_lo;
  wire take;
  wire allow;
  wire [15:0] vec;
  wire wake;
  wire mapped;
  reg [2:0] ev;

  function [15:0] vec_of;
    input [3:0] idx;
    begin
      vec_of = `IIC_VEC_BASE + (`IIC_VEC_STEP * {12'h000, idx});
    end
  endfunction

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `IIC_OFF_PEND) | (paddr == `IIC_OFF_ENABLE) | (paddr == `IIC_OFF_PRIO) |
                  (paddr == `IIC_OFF_AUTOCLR) | (paddr == `IIC_OFF_POWER) | (paddr == `IIC_OFF_STATUS) |
                  (paddr == `IIC_OFF_IRQ_STAT) | (paddr == `IIC_OFF_IRQ_MASK);
  assign pslverr = psel & penable & ~mapped;

  // disabled flags simply never reach the arbiter
  assign req = pend_reg & irq_enable_reg & {`IIC_NSRC{global_irq_enable | global_prev_reg}}; // RQ5 RQ6
  // a level already in service masks itself and anything lower
  assign req_hi = (in_hi_reg | stop_reg) ? 14'h0000 : (req & prio_reg); // RQ19 RQ11
  assign req_lo = (in_hi_reg | in_lo_reg | stop_reg) ? 14'h0000 : (req & ~prio_reg); // RQ1 RQ19

  iic_arbiter u_arb (
    .req_hi(req_hi),
    .req_lo(req_lo),
    .found(found),
    .found_hi(found_hi),
    .index(index)
  );

  // a global clear just issued still lets a single-cycle successor slip through
  assign allow = global_irq_enable | (global_prev_reg & instr_single_cycle); // RQ7
  // vectoring only at instruction boundaries, or straight out of idle
  assign take = found & allow & (instr_done | idle_reg); // RQ3
  assign vec = vec_of(index);
  // idle wakes on any enabled request not masked by a level in service or by stop, unless the wake was lost on entry
  assign wake = idle_reg & (|(req_hi | req_lo)) & ~lost_wake_reg; // RQ14 RQ18

  assign cpu_halt = (idle_reg & ~wake) | stop_reg; // RQ10 RQ11
  assign int_osc_enable = ~stop_reg; // RQ11
  assign timers_enable = ~stop_reg; // RQ11
  assign active_level = {in_hi_reg, in_lo_reg};
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always @* begin
    ev = 3'h0;
    ev[`IIC_EV_TAKE] = take;
    ev[`IIC_EV_IDLE_WAKE] = wake;
    ev[`IIC_EV_STOP] = wr & (paddr == `IIC_OFF_POWER) & pwdata[`IIC_STOP_BIT] & ~stop_reg;
  end

  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 14'h0000;
      irq_enable_reg <= 14'h0000;
      prio_reg <= 14'h0000;
      autoclr_reg <= `IIC_AUTOCLR_RST;
      power_control_reg <= 8'h00;
      global_irq_enable <= 1'b0;
      global_prev_reg <= 1'b0;
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
      lost_wake_reg <= 1'b0;
      in_hi_reg <= 1'b0;
      in_lo_reg <= 1'b0;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      long_call_instr <= 1'b0;
      call_vector <= `IIC_RESET_VEC;
      call_source <= 4'h0;
      restart_req <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      long_call_instr <= 1'b0;
      restart_req <= 1'b0;
      global_prev_reg <= global_irq_enable & instr_single_cycle ? 1'b0 : 1'b0;
      // software write-one-to-clear first; hardware sets below win
      if (wr && paddr == `IIC_OFF_PEND)
        pend_reg <= pend_reg & ~pwdata[13:0];
      if (wr && paddr == `IIC_OFF_ENABLE) begin
        irq_enable_reg <= pwdata[13:0];
        if (global_irq_enable && !pwdata[16 + `IIC_GLOBAL_BIT])
          global_prev_reg <= 1'b1;
        global_irq_enable <= pwdata[16 + `IIC_GLOBAL_BIT]; // RQ6 RQ8
      end
      if (wr && paddr == `IIC_OFF_PRIO)
        prio_reg <= pwdata[13:0]; // RQ1
      if (wr && paddr == `IIC_OFF_AUTOCLR)
        autoclr_reg <= pwdata[13:0];
      if (wr && paddr == `IIC_OFF_IRQ_MASK)
        irq_mask_reg <= pwdata[2:0];
      if (wr && paddr == `IIC_OFF_POWER) begin
        power_control_reg <= pwdata[7:0];
        if (pwdata[`IIC_IDLE_BIT]) begin
          idle_reg <= 1'b1; // RQ13
          // an interrupt landing with the idle write can lose later wakes
          lost_wake_reg <= take & instr_single_cycle; // RQ18
        end
        if (pwdata[`IIC_STOP_BIT])
          stop_reg <= 1'b1; // RQ11
      end
      if (take) begin
        long_call_instr <= 1'b1; // RQ3
        call_vector <= vec; // RQ15
        call_source <= index;
        if (found_hi)
          in_hi_reg <= 1'b1; // RQ19
        else
          in_lo_reg <= 1'b1;
        if (autoclr_reg[index])
          pend_reg[index] <= 1'b0; // RQ9
      end else if (return_from_isr_instr) begin
        // unwind the most recent level only
        if (in_hi_reg)
          in_hi_reg <= 1'b0; // RQ4
        else
          in_lo_reg <= 1'b0; // RQ4
      end
      if (wake)
        idle_reg <= 1'b0; // RQ14
      // supervisory or other resets end idle; stop only ends by reset
      if (supervisory_timer_reset) begin
        idle_reg <= 1'b0; // RQ16 RQ17
        stop_reg <= 1'b0; // RQ12
        lost_wake_reg <= 1'b0;
        in_hi_reg <= 1'b0;
        in_lo_reg <= 1'b0;
        restart_req <= 1'b1;
        call_vector <= `IIC_RESET_VEC; // RQ16
      end
      // events set sticky flags regardless of enable; set beats clear
      for (k = 0; k < `IIC_NSRC; k = k + 1) begin
        if (src_event[k] && !stop_reg)
          pend_reg[k] <= 1'b1; // RQ2
      end
      if (wr && paddr == `IIC_OFF_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      if (rd) begin
        case (paddr)
          `IIC_OFF_PEND: prdata <= {18'h00000, pend_reg};
          `IIC_OFF_ENABLE: prdata <= {8'h00, global_irq_enable, 7'h00, 2'h0, irq_enable_reg};
          `IIC_OFF_PRIO: prdata <= {18'h00000, prio_reg};
          `IIC_OFF_AUTOCLR: prdata <= {18'h00000, autoclr_reg};
          `IIC_OFF_POWER: prdata <= {30'h00000000, stop_reg, idle_reg};
          `IIC_OFF_STATUS: prdata <= {23'h000000, supervisory_timer_lock, lost_wake_reg, in_hi_reg, in_lo_reg,
                                      call_source};
          `IIC_OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat_reg};
          `IIC_OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* hw/iic_map.vh */
`ifndef IIC_MAP_VH
`define IIC_MAP_VH
// Function
// RQ1 - fourteen sources, each high or low priority
// RQ2 - pending flag sets regardless of enable
// RQ3 - after instruction ends, long call to vector
// RQ4 - return instruction resumes interrupted program
// RQ5 - disabled pending flag makes no request
// RQ6 - per-source enables gated by global enable
// RQ7 - clear global enable then single-cycle may take
// RQ8 - software follows global clear with two-byte op
// RQ9 - some flags auto-clear on vectoring
// RQ10 - idle halts cpu, clocks and state kept
// RQ11 - stop halts cpu, interrupts, internal oscillator
// RQ12 - after oscillators off only reset resumes
// RQ13 - idle bit write enters idle after instruction
// RQ14 - enabled interrupt clears idle and resumes
// RQ15 - resume after idle-setting instruction
// RQ16 - reset in idle restarts at zero
// RQ17 - supervisory timer reset ends idle, maybe disabled
// RQ18 - single-byte after idle write may miss wake
// RQ19 - high priority first, preempts low only
`define IIC_NSRC 14
`define IIC_OFF_PEND 12'h000
`define IIC_OFF_ENABLE 12'h004
`define IIC_OFF_PRIO 12'h008
`define IIC_OFF_AUTOCLR 12'h00C
`define IIC_OFF_POWER 12'h010
`define IIC_OFF_STATUS 12'h014
`define IIC_OFF_IRQ_STAT 12'h018
`define IIC_OFF_IRQ_MASK 12'h01C
`define IIC_GLOBAL_BIT 7
`define IIC_IDLE_BIT 0
`define IIC_STOP_BIT 1
`define IIC_AUTOCLR_RST 14'h0000
`define IIC_VEC_BASE 16'h0003
`define IIC_VEC_STEP 16'h0008
`define IIC_RESET_VEC 16'h0000
`define IIC_EV_TAKE 0
`define IIC_EV_IDLE_WAKE 1
`define IIC_EV_STOP 2
`endif

/* hw/iic_arbiter.v */
`include "iic_map.vh"
module iic_arbiter (
  input wire [13:0] req_hi,
  input wire [13:0] req_lo,
  output reg found,
  output reg found_hi,
  output reg [3:0] index
);
  integer i;
  // lowest index wins within a level; high level beats low
  always @* begin
    found = 1'b0;
    found_hi = 1'b0;
    index = 4'h0;
    for (i = `IIC_NSRC - 1; i >= 0; i = i - 1) begin
      if (req_lo[i]) begin
        found = 1'b1;
        index = i[3:0];
      end
    end
    for (i = `IIC_NSRC - 1; i >= 0; i = i - 1) begin
      if (req_hi[i]) begin
        found = 1'b1;
        found_hi = 1'b1; // RQ19
        index = i[3:0];
      end
    end
  end
endmodule

/* testbench/iic_assertions.sv */
module iic_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire supervisory_timer_reset,
  input wire long_call_instr,
  input wire [15:0] call_vector,
  input wire [3:0] call_source,
  input wire cpu_halt,
  input wire restart_req,
  input wire int_osc_enable,
  input wire timers_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire pw = psel && penable && pwrite && paddr == 12'h010;
  a_call_vector: assert property (long_call_instr |-> call_vector == {9'h0, call_source, 3'h3})
    else $error("vector off");
  a_restart_vector: assert property (restart_req |-> call_vector == 16'h0000)
    else $error("restart vector off");
  a_timer_restart: assert property (supervisory_timer_reset |-> ##[1:2] restart_req)
    else $error("no restart");
  a_stop_pair: assert property (int_osc_enable == timers_enable)
    else $error("osc and timers differ");
  a_stop_halts: assert property (!int_osc_enable |-> cpu_halt)
    else $error("stop without halt");
  a_stop_holds: assert property ($past(!int_osc_enable) && !$past(supervisory_timer_reset) |-> !int_osc_enable)
    else $error("stop left");
  a_stop_write: assert property (pw && pwdata[1] |=> !int_osc_enable)
    else $error("stop not entered");
  a_idle_write: assert property (pw && pwdata[1:0] == 2'h1 |-> ##[1:2] (cpu_halt || long_call_instr))
    else $error("idle not entered");
  c_call: cover property (long_call_instr);
  c_restart: cover property (restart_req);
  c_stop: cover property (!int_osc_enable);
  c_idle: cover property (cpu_halt && int_osc_enable);
endmodule
bind iic_interrupt_and_idle iic_assertions chk (.*);

/* testbench/iic_cpu_model.sv */
module iic_cpu_model (
  input wire pclk,
  input wire presetn,
  input wire cpu_halt,
  input wire ret_go,
  input wire [1:0] gap,
  output logic instr_done,
  output logic instr_single_cycle,
  output logic return_from_isr_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // always a two-byte successor, so no lost wake
  assign instr_single_cycle = 1'b0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
      instr_done <= 1'b0;
      return_from_isr_instr <= 1'b0;
    end else begin
      cnt <= (cnt >= gap) ? 2'h0 : cnt + 2'h1;
      instr_done <= !cpu_halt && cnt >= gap;
      return_from_isr_instr <= ret_go;
    end
  end
endmodule

/* testbench/iic_interrupt_and_idle_bench.sv */
module iic_interrupt_and_idle_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ret_go = 0;
  logic supervisory_timer_reset = 0, supervisory_timer_lock = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, pend_m = 0;
  logic [13:0] src_event = 0;
  logic [1:0] gap = 0, active_level;
  logic [15:0] call_vector, vv;
  logic [3:0] call_source, ss;
  logic pready, pslverr, instr_done, instr_single_cycle, return_from_isr_instr, er;
  logic long_call_instr, cpu_halt, restart_req, int_osc_enable, timers_enable, irq;
  int failures = 0, num_checks = 0, ncall = 0, nrst = 0, i, j;
  iic_interrupt_and_idle DUT (.*);
  iic_cpu_model cpu (.*);
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (long_call_instr === 1'b1) begin
      ncall++;
      vv = call_vector;
      ss = call_source;
    end
    if (restart_req === 1'b1) nrst++;
  end
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk("read", x, rd);
  endtask
  task automatic ev(input int n);
    src_event <= 14'h1 << n;
    pend_m |= 32'h1 << n;
    @(posedge pclk) src_event <= 0;
  endtask
  task automatic svc_end;
    wr(12'h000, pend_m);
    pend_m = 0;
    ret_go <= 1;
    @(posedge pclk) ret_go <= 0;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h1CBE));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 8; i++) rdc(i * 4, 0);
    apb(0, 12'h020, 32'hFFFFFFFF);
    chk("err", 1, er);
    chk("rdz", 0, rd);
    $display("test reset done");
    gap <= $urandom % 4;
    i = $urandom % 14;
    ev(i);
    rdc(12'h000, pend_m);
    chk("calls", 0, ncall);
    wr(12'h004, 32'h3FFF);
    repeat (8) @(posedge pclk);
    chk("calls", 0, ncall);
    wr(12'h004, 32'h803FFF);
    repeat (12) @(posedge pclk);
    chk("calls", 1, ncall);
    chk("vec", 3 + 8 * i, vv);
    chk("lvl", 1, active_level);
    svc_end;
    $display("test enable done");
    j = (i + 1 + $urandom % 13) % 14;
    wr(12'h008, 32'h1 << j);
    wr(12'h004, 32'h3FFF);
    ev(i);
    ev(j);
    wr(12'h004, 32'h803FFF);
    repeat (12) @(posedge pclk);
    chk("src", j, ss);
    chk("calls", 2, ncall);
    chk("lvl", 2, active_level);
    svc_end;
    $display("test priority done");
    wr(12'h00C, 32'h1 << i);
    wr(12'h010, 1);
    chk("halt", 1, cpu_halt);
    ev(i);
    repeat (8) @(posedge pclk);
    chk("calls", 3, ncall);
    chk("halt", 0, cpu_halt);
    rdc(12'h010, 0);
    rdc(12'h000, 0);
    svc_end;
    $display("test idle done");
    chk("irq", 0, irq);
    wr(12'h01C, 7);
    chk("irq", 1, irq);
    rdc(12'h018, 3);
    wr(12'h018, 3);
    chk("irq", 0, irq);
    $display("test irq done");
    wr(12'h010, 2);
    chk("osc", 0, int_osc_enable);
    chk("tmr", 0, timers_enable);
    ev(i);
    repeat (8) @(posedge pclk);
    chk("calls", 3, ncall);
    supervisory_timer_reset <= 1;
    @(posedge pclk) supervisory_timer_reset <= 0;
    repeat (4) @(posedge pclk);
    chk("rst", 1, nrst);
    chk("vec", 0, call_vector);
    chk("osc", 1, int_osc_enable);
    $display("test stop done");
    print_verdict;
  end
endmodule
